// ==== verilog/swdt_pkg.sv ====
/*
 system watchdog timer package: window offsets, control bit positions,
 reset values, state encoding and timing constants.
 assumes a 50 MHz power-management logic clock.
*/
package swdt_pkg;
	// register offsets inside the memory window (byte addresses)
	localparam logic [2:0] OFF_CTRL = 3'h0;
	localparam logic [2:0] OFF_COUNT = 3'h4;
	localparam int WIN_LSB = 3;
	// control / status bit positions
	localparam int BIT_TRIG = 7;
	localparam int BIT_DIS = 3;
	localparam int BIT_ACT = 2;
	localparam int BIT_FIRED = 1;
	localparam int BIT_RUN = 0;
	// interval field
	localparam int COUNT_W = 10;
	// reset values
	localparam logic RST_ACT = 1'b0;
	localparam logic RST_FIRED = 1'b0;
	localparam logic [COUNT_W-1:0] RST_COUNT = 10'h000;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;
	// timing: watchdog tick period
	localparam int CLK_NS = 20;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = (TICK_NS / CLK_NS < 1) ? 1 : TICK_NS / CLK_NS;
	typedef enum logic [2:0] {
		SWDT_STOP = 3'b001,
		SWDT_RUN = 3'b010,
		SWDT_COUNT = 3'b100
	} swdt_state_t;
endpackage

// ==== verilog/swdt_top.sv ====
/*
 system watchdog timer: control/status and count registers in a memory
 window, countdown, expiry action and sticky fired flag.
 assumes a simple single-cycle memory request port, the window base from
 configuration space, and a synchronous hardware-disable level.
*/
`timescale 1ns/10ps
`default_nettype none
module swdt_top #(
	parameter int COUNT_W = swdt_pkg::COUNT_W,
	parameter int TICK_CYCLES = swdt_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [31:0] mmio_base,
	input wire logic [31:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [3:0] mem_be,
	input wire logic [31:0] mem_wdata,
	output logic [31:0] mem_rdata,
	output logic mem_ack,
	input wire logic hw_disable,
	output logic expire_reset,
	output logic expire_poweroff
);
	localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

	generate
		if (COUNT_W < 1 || COUNT_W > 31 || TICK_CYCLES < 1) begin : g_bad
			$error("swdt_top: unsupported COUNT_W or TICK_CYCLES");
		end
	endgenerate

	function automatic logic win_hit(input logic [31:0] a, input logic [31:0] b,
			input logic [2:0] off);
		win_hit = (a[31:swdt_pkg::WIN_LSB] == b[31:swdt_pkg::WIN_LSB]) &&
			(a[swdt_pkg::WIN_LSB-1:0] == off);
	endfunction

	swdt_pkg::swdt_state_t state, next_state;
	logic [COUNT_W-1:0] interval, next_interval;
	logic [COUNT_W-1:0] counter, next_counter;
	logic [TW-1:0] tick_cnt, next_tick_cnt;
	logic action, next_action;
	logic fired, next_fired;
	logic next_expire_reset, next_expire_poweroff;
	logic [31:0] next_mem_rdata;
	logic next_mem_ack;

	logic hit_ctrl, hit_count;
	logic wr_ctrl, wr_count, trig, run_set, run_clr, fire_clr, tick, expire;

	// address decode inside the window
	always_comb begin
		hit_ctrl = win_hit(mem_addr, mmio_base, swdt_pkg::OFF_CTRL);
		hit_count = win_hit(mem_addr, mmio_base, swdt_pkg::OFF_COUNT);
		wr_ctrl = mem_wr && hit_ctrl && mem_be[0];
		wr_count = mem_wr && hit_count;
		trig = wr_ctrl && mem_wdata[swdt_pkg::BIT_TRIG];
		run_set = wr_ctrl && mem_wdata[swdt_pkg::BIT_RUN];
		run_clr = wr_ctrl && !mem_wdata[swdt_pkg::BIT_RUN];
		fire_clr = wr_ctrl && mem_wdata[swdt_pkg::BIT_FIRED];
		tick = (state == swdt_pkg::SWDT_COUNT) && (tick_cnt == TICK_LAST);
		expire = tick && !trig && !run_clr && !hw_disable &&
			(counter <= COUNT_W'(1));
	end

	// watchdog state, interval, counter and tick prescaler
	always_comb begin
		next_state = state;
		next_interval = interval;
		next_counter = counter;
		next_tick_cnt = tick_cnt;
		next_action = action;
		next_fired = fired;
		next_expire_reset = 1'b0;
		next_expire_poweroff = 1'b0;
		if (wr_ctrl) begin
			next_action = mem_wdata[swdt_pkg::BIT_ACT];
		end
		if (wr_count) begin
			// stored only; loaded into counter at the next trigger while running
			next_interval = mem_wdata[COUNT_W-1:0];
		end
		case (state)
			swdt_pkg::SWDT_STOP: begin
				if (run_set) begin
					next_state = swdt_pkg::SWDT_RUN;
				end
			end
			swdt_pkg::SWDT_RUN: begin
				if (run_clr) begin
					next_state = swdt_pkg::SWDT_STOP;
				end else if (trig) begin
					next_state = swdt_pkg::SWDT_COUNT;
					next_counter = interval;
					next_tick_cnt = '0;
				end
			end
			swdt_pkg::SWDT_COUNT: begin
				if (run_clr) begin
					next_state = swdt_pkg::SWDT_STOP;
				end else if (trig) begin
					next_counter = interval;
					next_tick_cnt = '0;
				end else if (tick) begin
					next_tick_cnt = '0;
					next_counter = (counter == '0) ? counter : counter - COUNT_W'(1);
					if (expire) begin
						next_state = swdt_pkg::SWDT_RUN;
						next_expire_reset = !action;
						next_expire_poweroff = action;
					end
				end else begin
					next_tick_cnt = tick_cnt + TW'(1);
				end
			end
			default: begin
				next_state = swdt_pkg::SWDT_STOP;
			end
		endcase
		if (hw_disable) begin
			next_state = swdt_pkg::SWDT_STOP;
		end
		// set wins over a clear arriving in the same cycle
		next_fired = (fired && !fire_clr) || expire;
	end

	// read answer, one cycle after the request
	always_comb begin
		next_mem_ack = mem_rd || mem_wr;
		next_mem_rdata = swdt_pkg::RST_RDATA;
		if (mem_rd && hit_ctrl) begin
			// trigger and reserved bits stay zero
			next_mem_rdata[swdt_pkg::BIT_DIS] = hw_disable;
			next_mem_rdata[swdt_pkg::BIT_ACT] = action;
			next_mem_rdata[swdt_pkg::BIT_FIRED] = fired;
			next_mem_rdata[swdt_pkg::BIT_RUN] = (state != swdt_pkg::SWDT_STOP);
		end else if (mem_rd && hit_count) begin
			next_mem_rdata = {{(32-COUNT_W){1'b0}}, counter};
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= swdt_pkg::SWDT_STOP;
			interval <= COUNT_W'(swdt_pkg::RST_COUNT);
			counter <= COUNT_W'(swdt_pkg::RST_COUNT);
			tick_cnt <= '0;
			action <= swdt_pkg::RST_ACT;
			fired <= swdt_pkg::RST_FIRED;
			expire_reset <= 1'b0;
			expire_poweroff <= 1'b0;
			mem_rdata <= swdt_pkg::RST_RDATA;
			mem_ack <= 1'b0;
		end else begin
			state <= next_state;
			interval <= next_interval;
			counter <= next_counter;
			tick_cnt <= next_tick_cnt;
			action <= next_action;
			fired <= next_fired;
			expire_reset <= next_expire_reset;
			expire_poweroff <= next_expire_poweroff;
			mem_rdata <= next_mem_rdata;
			mem_ack <= next_mem_ack;
		end
	end

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	property p_trig_reads_zero;
		(mem_rd && hit_ctrl) |=> (mem_ack && mem_rdata[31:4] == 28'h0000000);
	endproperty
	a_trig_reads_zero: assert property (p_trig_reads_zero)
		else $error("trigger or reserved bit read nonzero");

	property p_trig_ignored_stopped;
		(state == swdt_pkg::SWDT_STOP && trig) |=>
			(state != swdt_pkg::SWDT_COUNT && counter == $past(counter));
	endproperty
	a_trig_ignored_stopped: assert property (p_trig_ignored_stopped)
		else $error("trigger acted while stopped");

	property p_trig_loads;
		(state == swdt_pkg::SWDT_RUN && trig && !run_clr && !hw_disable) |=>
			(state == swdt_pkg::SWDT_COUNT && counter == $past(interval));
	endproperty
	a_trig_loads: assert property (p_trig_loads)
		else $error("trigger did not load the interval");

	property p_action;
		expire |=> ($past(action) ? (expire_poweroff && !expire_reset) :
			(expire_reset && !expire_poweroff)) ##1 !(expire_reset || expire_poweroff);
	endproperty
	a_action: assert property (p_action)
		else $error("wrong expiry action");

	property p_fired_set;
		expire |=> fired;
	endproperty
	a_fired_set: assert property (p_fired_set)
		else $error("fired flag not set on expiry");

	property p_fired_clear;
		(wr_ctrl && !expire) |=>
			(fired == ($past(fired) && !$past(mem_wdata[swdt_pkg::BIT_FIRED])));
	endproperty
	a_fired_clear: assert property (p_fired_clear)
		else $error("fired flag write-one-clear broken");

	property p_run_read;
		(mem_rd && hit_ctrl) |=>
			(mem_rdata[swdt_pkg::BIT_RUN] == ($past(state) != swdt_pkg::SWDT_STOP) &&
			mem_rdata[swdt_pkg::BIT_DIS] == $past(hw_disable));
	endproperty
	a_run_read: assert property (p_run_read)
		else $error("run or disable bit reads wrong");

	property p_start_waits;
		(state == swdt_pkg::SWDT_STOP && run_set && !hw_disable) |=>
			state == swdt_pkg::SWDT_RUN;
	endproperty
	a_start_waits: assert property (p_start_waits)
		else $error("run write from stop did not enter running only");

	property p_run_again;
		(state == swdt_pkg::SWDT_COUNT && run_set && !trig && !tick && !hw_disable) |=>
			(state == swdt_pkg::SWDT_COUNT && counter == $past(counter));
	endproperty
	a_run_again: assert property (p_run_again)
		else $error("run write while running changed countdown");

	property p_count_read;
		(mem_rd && hit_count) |=> mem_rdata[COUNT_W-1:0] == $past(counter);
	endproperty
	a_count_read: assert property (p_count_read)
		else $error("count read not live counter");

	property p_decrement;
		(tick && !expire && !trig && !run_clr && !hw_disable) |=>
			counter == $past(counter) - COUNT_W'(1);
	endproperty
	a_decrement: assert property (p_decrement)
		else $error("counter did not decrement on tick");

	property p_disable_stops;
		hw_disable |=>
			(state == swdt_pkg::SWDT_STOP && !expire_reset && !expire_poweroff);
	endproperty
	a_disable_stops: assert property (p_disable_stops)
		else $error("hardware disable did not stop the watchdog");

	property p_idle_answer;
		!(mem_rd || mem_wr) |=>
			(!mem_ack && mem_rdata == 32'h0000_0000);
	endproperty
	a_idle_answer: assert property (p_idle_answer)
		else $error("answer without a request");

	property p_run_holds;
		(state == swdt_pkg::SWDT_RUN && !trig) |=>
			counter == $past(counter);
	endproperty
	a_run_holds: assert property (p_run_holds)
		else $error("counter moved before a trigger");

	property p_reload;
		(state == swdt_pkg::SWDT_COUNT && trig && !run_clr && !hw_disable) |=>
			(state == swdt_pkg::SWDT_COUNT && counter == $past(interval));
	endproperty
	a_reload: assert property (p_reload)
		else $error("trigger did not reload the interval");

	property p_fired_holds;
		(!expire && !fire_clr) |=> fired == $past(fired);
	endproperty
	a_fired_holds: assert property (p_fired_holds)
		else $error("fired flag changed without cause");

	c_expire_reset: cover property (expire && !action);
	c_expire_poweroff: cover property (expire && action);
	c_fired_cleared: cover property (fired && fire_clr && !expire);
	c_reload: cover property (state == swdt_pkg::SWDT_COUNT && trig);
	c_disable: cover property (hw_disable && state != swdt_pkg::SWDT_STOP);
endmodule
`default_nettype wire

// ==== testbench/system_watchdog_timer_tb.sv ====
/*
 self-checking bench for the system watchdog timer: window reads and writes,
 trigger, run, action, fired flag, hardware disable and expiry timing.
 assumes swdt_top with a short tick prescaler and a single-cycle request port.
*/
`timescale 1ns/10ps
`default_nettype none
module system_watchdog_timer_tb;
	localparam int TK = 4;
	localparam logic [31:0] BASE = 32'h0001_0000;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [31:0] mem_addr = 32'h0000_0000;
	logic mem_rd = 1'b0;
	logic mem_wr = 1'b0;
	logic [3:0] mem_be = 4'h0;
	logic [31:0] mem_wdata = 32'h0000_0000;
	logic hw_disable = 1'b0;
	logic [31:0] mem_rdata;
	logic mem_ack;
	logic expire_reset;
	logic expire_poweroff;
	int bad_count = 0;
	int cmp_count = 0;
	int seed;
	int n;
	always #10 clk = ~clk;
	swdt_top #(.COUNT_W(10), .TICK_CYCLES(TK)) u_dut (.clk(clk), .reset_n(reset_n),
		.mmio_base(BASE), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_be(mem_be), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
		.hw_disable(hw_disable), .expire_reset(expire_reset),
		.expire_poweroff(expire_poweroff));
	function automatic logic [31:0] ctrl(input logic dis, input logic act, input logic fired,
			input logic run);
		return {28'h0000000, dis, act, fired, run};
	endfunction
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report();
		if (bad_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	// one request pulse, answer checked in the acknowledge cycle
	task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
			output logic [31:0] rd);
		@(negedge clk);
		mem_rd = ~wr;
		mem_wr = wr;
		mem_addr = addr;
		mem_wdata = wd;
		mem_be = 4'hf;
		@(negedge clk);
		mem_rd = 1'b0;
		mem_wr = 1'b0;
		chk("mem_ack", {31'h0, mem_ack}, 32'h1);
		rd = mem_rdata;
	endtask
	task automatic reg_wr(input logic [31:0] off, input logic [31:0] wd);
		logic [31:0] d;
		bus(1'b1, BASE + off, wd, d);
	endtask
	task automatic reg_rd(input logic [31:0] off, input logic [31:0] exp, input string name);
		logic [31:0] d;
		bus(1'b0, BASE + off, 32'h0000_0000, d);
		chk(name, d, exp);
	endtask
	// program interval, trigger, optionally rewrite run mid-count, time the expiry
	task automatic expire(input int k, input logic act, input logic mid);
		int c;
		reg_wr(32'h4, k);
		reg_wr(32'h0, ctrl(1'b0, act, 1'b0, 1'b1) | 32'h80);
		c = 0;
		if (mid) begin
			cyc(TK);
			reg_wr(32'h0, ctrl(1'b0, act, 1'b0, 1'b1));
			c = TK + 2;
		end
		while (expire_reset !== 1'b1 && expire_poweroff !== 1'b1 && c < k * TK + 20) begin
			@(negedge clk);
			c++;
		end
		chk("expire_time", 32'(c >= k * TK - 2 && c <= k * TK + 3), 32'h1);
		chk("expire_kind", {30'h0, expire_poweroff, expire_reset}, act ? 32'h2 : 32'h1);
		reg_rd(32'h0, ctrl(1'b0, act, 1'b1, 1'b1), "fired_set");
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		final_report();
	end
	initial begin
		seed = 32'hfbd8ec32;
		repeat (3) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		reg_rd(32'h0, 32'h0, "ctrl_reset");
		reg_rd(32'h4, 32'h0, "count_reset");
		reg_rd(32'h8, 32'h0, "unmapped");
		reg_wr(32'h4, 32'h3);
		reg_wr(32'h0, 32'h80);
		cyc(3 * TK);
		reg_rd(32'h4, 32'h0, "count_stopped");
		reg_wr(32'h0, 32'hffff_ff71);
		reg_rd(32'h0, ctrl(1'b0, 1'b0, 1'b0, 1'b1), "ctrl_run");
		cyc(3 * TK);
		reg_rd(32'h4, 32'h0, "count_idle");
		expire(2, 1'b0, 1'b0);
		reg_wr(32'h0, 32'h1);
		reg_rd(32'h0, ctrl(1'b0, 1'b0, 1'b1, 1'b1), "fired_keep");
		reg_wr(32'h0, 32'h3);
		reg_rd(32'h0, ctrl(1'b0, 1'b0, 1'b0, 1'b1), "fired_clear");
		expire(3, 1'b1, 1'b1);
		expire(1, 1'b0, 1'b0);
		expire(10'h3ff, 1'b1, 1'b0);
		repeat (4) begin
			n = 1 + ($random(seed) & 15);
			expire(n, 1'($random(seed)), 1'b0);
		end
		reg_wr(32'h0, 32'h2);
		reg_wr(32'h0, 32'h1);
		hw_disable = 1'b1;
		cyc(2);
		reg_wr(32'h4, 32'h5);
		reg_wr(32'h0, 32'h81);
		reg_rd(32'h4, 32'h0, "count_disabled");
		reg_rd(32'h0, ctrl(1'b1, 1'b0, 1'b0, 1'b0), "ctrl_disabled");
		hw_disable = 1'b0;
		reg_wr(32'h0, 32'h1);
		expire(1, 1'b0, 1'b0);
		reset_n = 1'b0;
		cyc(2);
		reset_n = 1'b1;
		reg_rd(32'h0, 32'h0, "fired_power_cycle");
		final_report();
	end
endmodule
`default_nettype wire
